// *** bench/resistance_to_frequency_counters_tb.sv ***
// register-level bench of the converter
`timescale 1ns/1ps
module resistance_to_frequency_counters_tb import rf_conv_pkg::*;;
    // ====================================================================
    // signals
    logic               i_clk = 1'h0, i_rst_b = 1'h0, hsel = 1'h0;
    logic               hwrite = 1'h0;
    logic [1:0]         htrans = 2'h0;
    logic [DATA_W-1:0]  haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic [DATA_W-1:0]  rdata;
    logic [COUNT_W-1:0] win, cnt, k, s;
    wire                hready, hresp, sense, slow, fast, ref_en, sen_en;
    wire                chan, styp, irq;
    wire [DATA_W-1:0]   hrdata;
    int                 failures = 0, n_tests = 0;
    logic [IDX_W-1:0]   regs [4] = '{IDX_CONFIG, IDX_RUN, IDX_IRQ_EN,
                                     IDX_IRQ_FLAG};

    initial forever #4 i_clk = ~i_clk;

    rf_converter u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_sense_oscillator_clock(sense), .i_slow_oscillator_clock(slow),
        .i_fast_oscillator_clock(fast), .o_reference_osc_enable(ref_en),
        .o_sensor_osc_enable(sen_en), .o_channel_select(chan),
        .o_sensor_type_select(styp), .o_converter_irq(irq));
    rf_osc_model u_osc (.i_clk(i_clk), .i_run(ref_en | sen_en),
        .o_sense(sense), .o_slow(slow), .o_fast(fast));

    // ====================================================================
    // bus access and checks
    task automatic bus(input logic w, input logic [IDX_W-1:0] ix,
                       input logic [DATA_W-1:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {14'h0, ix, 2'h0};
        do @(posedge i_clk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clk); while (hready !== 1'h1);
        rdata = hrdata;
    endtask
    task automatic chk(input logic [DATA_W-1:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [IDX_W-1:0] ix, input logic [31:0] e);
        bus(1'h0, ix, 32'h0000_0000);
        chk(rdata, e);
    endtask
    // plain writes low nibble first; read-modify-write would tear a count
    task automatic put_cnt(input logic [IDX_W-1:0] b,
                           input logic [COUNT_W-1:0] v);
        for (int i = 0; i < NIB_N; i++)
            bus(1'h1, b + 16'(i), {28'h0, v[4*i +: 4]});
    endtask
    task automatic get_cnt(input logic [IDX_W-1:0] b,
                           output logic [COUNT_W-1:0] v);
        for (int i = 0; i < NIB_N; i++) begin
            bus(1'h0, b + 16'(i), 32'h0000_0000);
            v[4*i +: 4] = rdata[3:0];
        end
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 400; n++) begin
            bus(1'h0, IDX_RUN, 32'h0000_0000);
            if (rdata[1:0] === 2'h0) return;
        end
        chk(rdata, 32'h0000_0000);
    endtask
    task automatic ref_run(input logic [DATA_W-1:0] cfg,
                           output logic [COUNT_W-1:0] kk);
        bus(1'h1, IDX_CONFIG, cfg);
        put_cnt(IDX_OSC_CNT, 20'hf_fff0);
        put_cnt(IDX_WIN_CNT, 20'h0_0000);
        bus(1'h1, IDX_RUN, 32'h0000_0002);
        bus(1'h1, IDX_RUN, 32'h0000_0000);
        rd(IDX_RUN, 32'h0000_0002);
        wait_idle();
        get_cnt(IDX_OSC_CNT, cnt);
        chk({12'h0, cnt}, 32'h0000_0000);
        rd(IDX_IRQ_FLAG, 32'h0000_0002);
        get_cnt(IDX_WIN_CNT, win);
        kk = -win;
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ====================================================================
    // tests
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'h1;
        @(posedge i_clk);
        foreach (regs[j]) rd(regs[j], 32'h0000_0000);
        bus(1'h1, 16'h0123, 32'h0000_000f);
        rd(16'h0123, 32'h0000_0000);
        bus(1'h1, IDX_CONFIG, 32'h0000_0003);
        rd(IDX_CONFIG, 32'h0000_0003);
        chk({30'h0, styp, chan}, 32'h0000_0003);
        bus(1'h1, IDX_IRQ_EN, 32'h0000_0003);
        rd(IDX_IRQ_EN, 32'h0000_0003);
        ref_run(32'h0000_0004, k);
        chk({31'h0, k >= 20'h7 && k <= 20'h9}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        get_cnt(IDX_WIN_CNT, cnt);
        chk({12'h0, cnt}, {12'h0, win});
        bus(1'h1, IDX_IRQ_FLAG, 32'h0000_0002);
        rd(IDX_IRQ_FLAG, 32'h0000_0000);
        put_cnt(IDX_OSC_CNT, 20'h0_0000);
        put_cnt(IDX_WIN_CNT, win);
        bus(1'h1, IDX_RUN, 32'h0000_0001);
        rd(IDX_RUN, 32'h0000_0001);
        wait_idle();
        get_cnt(IDX_OSC_CNT, s);
        chk({31'h0, s + 20'h3 >= 2 * k && s <= 2 * k + 20'h3}, 32'h1);
        get_cnt(IDX_WIN_CNT, cnt);
        chk({12'h0, cnt}, 32'h0000_0000);
        rd(IDX_IRQ_FLAG, 32'h0000_0001);
        bus(1'h1, IDX_IRQ_EN, 32'h0000_0002);
        @(posedge i_clk);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        bus(1'h1, IDX_IRQ_FLAG, 32'h0000_0001);
        ref_run(32'h0000_0000, k);
        chk({31'h0, k >= 20'h1 && k <= 20'h3}, 32'h1);
        bus(1'h1, IDX_IRQ_FLAG, 32'h0000_0003);
        // window far off, so the oscillation counter overflows first
        put_cnt(IDX_OSC_CNT, 20'hf_fff8);
        put_cnt(IDX_WIN_CNT, 20'hf_ff00);
        bus(1'h1, IDX_RUN, 32'h0000_0001);
        wait_idle();
        rd(IDX_RUN, 32'h0000_0004);
        rd(IDX_IRQ_FLAG, 32'h0000_0001);
        put_cnt(IDX_WIN_CNT, 20'h0_0002);
        bus(1'h1, IDX_RUN, 32'h0000_0002);
        wait_idle();
        rd(IDX_RUN, 32'h0000_0008);
        rd(IDX_IRQ_FLAG, 32'h0000_0003);
        bus(1'h1, IDX_RUN, 32'h0000_0008);
        rd(IDX_RUN, 32'h0000_0000);
        close_out();
    end
    initial begin
        repeat (30000) @(posedge i_clk);
        failures++;
        close_out();
    end
endmodule

// *** bench/rf_converter_checker.sv ***
// port assertions of the converter
`timescale 1ns/1ps
module rf_converter_checker import rf_conv_pkg::*; (
    input wire logic              i_clk,
    input wire logic              i_rst_b,
    input wire logic              i_hsel,
    input wire logic [DATA_W-1:0] i_haddr,
    input wire logic [1:0]        i_htrans,
    input wire logic              i_hwrite,
    input wire logic [DATA_W-1:0] i_hwdata,
    input wire logic              i_hready,
    input wire logic              o_hreadyout,
    input wire logic [DATA_W-1:0] o_hrdata,
    input wire logic              o_reference_osc_enable,
    input wire logic              o_sensor_osc_enable,
    input wire logic              o_channel_select,
    input wire logic              o_sensor_type_select,
    input wire logic              o_converter_irq
);
    // ====================================================================
    // bus tracking
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire take = i_hsel & i_htrans[HTRANS_ACTIVE_BIT] & i_hready;
    logic             wr_reg;
    logic             rd_reg;
    logic [IDX_W-1:0] idx_reg;
    logic [1:0]       en_reg;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_reg  <= 1'h0;
            rd_reg  <= 1'h0;
            idx_reg <= 16'h0000;
            en_reg  <= 2'h0;
        end else begin
            wr_reg  <= take & i_hwrite;
            rd_reg  <= take & !i_hwrite;
            idx_reg <= i_haddr[ADDR_MSB:ADDR_LSB];
            if (wr_reg && idx_reg == IDX_IRQ_EN) en_reg <= i_hwdata[1:0];
        end
    end
    wire wr_run = wr_reg && idx_reg == IDX_RUN;
    wire wr_cfg = wr_reg && idx_reg == IDX_CONFIG;
    wire idle   = !o_reference_osc_enable && !o_sensor_osc_enable;
    wire sen_go = wr_run && i_hwdata[0];

    // ====================================================================
    // assertions
    chk_one_run: assert property (
        !(o_reference_osc_enable && o_sensor_osc_enable))
        else $error("both runs active");
    chk_ref_start: assert property (
        wr_run && i_hwdata[1] && idle |=> o_reference_osc_enable)
        else $error("reference run did not start");
    chk_sen_start: assert property (
        wr_run && i_hwdata[0] && !i_hwdata[1] && idle
        |=> o_sensor_osc_enable) else $error("sensor run did not start");
    chk_sen_cause: assert property (
        $rose(o_sensor_osc_enable) |-> $past(sen_go))
        else $error("sensor run without start write");
    chk_cfg_bits: assert property (
        wr_cfg |=> o_channel_select == $past(i_hwdata[0])
        && o_sensor_type_select == $past(i_hwdata[1]))
        else $error("config outputs wrong");
    chk_ref_done: assert property (
        $fell(o_reference_osc_enable) && en_reg[1] |-> ##[0:1] o_converter_irq)
        else $error("no reference done interrupt");
    chk_sen_done: assert property (
        $fell(o_sensor_osc_enable) && en_reg[0] |-> ##[0:1] o_converter_irq)
        else $error("no sensor done interrupt");
    chk_irq_mask: assert property (
        en_reg == 2'h0 |-> !o_converter_irq) else $error("masked irq seen");
    chk_read_wait: assert property (
        rd_reg |-> !o_hreadyout ##1 o_hreadyout) else $error("read wait");
    chk_upper_zero: assert property (
        o_hrdata[DATA_W-1:NIB_W] == 28'h000_0000)
        else $error("upper read bits set");
    cov_ref: cover property ($rose(o_reference_osc_enable));
    cov_sen: cover property ($rose(o_sensor_osc_enable));
    cov_irq: cover property ($rose(o_converter_irq));
endmodule

bind rf_converter rf_converter_checker u_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata),
    .o_reference_osc_enable(o_reference_osc_enable),
    .o_sensor_osc_enable(o_sensor_osc_enable),
    .o_channel_select(o_channel_select),
    .o_sensor_type_select(o_sensor_type_select),
    .o_converter_irq(o_converter_irq));

// *** bench/rf_osc_model.sv ***
// oscillator model: sense clock during a run, free-running window clocks
`timescale 1ns/1ps
module rf_osc_model (
    input  wire logic i_clk,
    input  wire logic i_run,
    output logic      o_sense,
    output logic      o_slow,
    output logic      o_fast
);
    // ====================================================================
    // sense oscillator
    logic [3:0] div_reg = 4'h0;
    logic       sense_reg = 1'h0;
    // the cr oscillator stands still at 0 outside a run
    always_ff @(posedge i_clk) begin
        div_reg   <= div_reg + 4'h1;
        sense_reg <= i_run ? ~sense_reg : 1'h0;
    end
    assign o_sense = sense_reg;
    assign o_fast  = div_reg[1];
    assign o_slow  = div_reg[3];
endmodule

// *** hw/counter_if.sv ***
// control and status bundle between the converter and one nibble counter
`timescale 1ns/1ps
interface counter_if import rf_conv_pkg::*; #(
    parameter int WIDTH = COUNT_W
) ();
    logic                 wr_en;
    logic [NIB_SEL_W-1:0] wr_nibble;
    logic [NIB_W-1:0]     wr_data;
    logic                 step;
    logic                 down;
    logic [WIDTH-1:0]     value;
    logic                 lands_zero;

    modport ctl (output wr_en, wr_nibble, wr_data, step, down,
                 input  value, lands_zero);
    modport cnt (input  wr_en, wr_nibble, wr_data, step, down,
                 output value, lands_zero);
endinterface

// *** hw/nibble_counter.sv ***
// up/down counter written one nibble at a time, no reset value
`timescale 1ns/1ps
module nibble_counter import rf_conv_pkg::*; #(
    parameter int WIDTH = COUNT_W
) (
    input  wire logic i_clk,
    counter_if.cnt    port_c
);
    localparam int NIBS = WIDTH / NIB_W;

    logic [WIDTH-1:0] value_reg;
    logic [WIDTH-1:0] value_next;
    wire  [WIDTH-1:0] stepped = port_c.down ? value_reg - 1'b1
                                            : value_reg + 1'b1;

    // ====================================================================
    // nibble write beats the count step in the same cycle
    genvar k;
    generate
        for (k = 0; k < NIBS; k++) begin : g_nib
            assign value_next[k*NIB_W +: NIB_W] =
                (port_c.wr_en && port_c.wr_nibble == NIB_SEL_W'(k))
                    ? port_c.wr_data
                    : (port_c.step ? stepped[k*NIB_W +: NIB_W]
                                   : value_reg[k*NIB_W +: NIB_W]);
        end
    endgenerate

    assign port_c.value      = value_reg;
    assign port_c.lands_zero = port_c.step && !port_c.wr_en
                               && stepped == '0;

    // no reset on purpose: contents are undefined after reset
    always_ff @(posedge i_clk) begin
        value_reg <= value_next;
    end

endmodule

// *** hw/rf_conv_pkg.sv ***
// constants, register map and types of the resistance-to-frequency converter
package rf_conv_pkg;

    // ====================================================================
    // widths
    localparam int DATA_W    = 32;
    localparam int COUNT_W   = 20;
    localparam int NIB_W     = 4;
    localparam int NIB_N     = 5;
    localparam int NIB_SEL_W = 3;
    localparam int IDX_W     = 16;
    localparam int ADDR_LSB  = 2;
    localparam int ADDR_MSB  = ADDR_LSB + IDX_W - 1;

    // ====================================================================
    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CONFIG   = 16'hff90;
    localparam logic [IDX_W-1:0] IDX_RUN      = 16'hff91;
    localparam logic [IDX_W-1:0] IDX_OSC_CNT  = 16'hff92;
    localparam logic [IDX_W-1:0] IDX_WIN_CNT  = 16'hff97;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN   = 16'hffe7;
    localparam logic [IDX_W-1:0] IDX_IRQ_FLAG = 16'hfff7;

    // ====================================================================
    // field positions
    localparam int CFG_CHANNEL_BIT  = 0;
    localparam int CFG_TYPE_BIT     = 1;
    localparam int CFG_CLKSEL_BIT   = 2;
    localparam int RUN_SENSOR_BIT   = 0;
    localparam int RUN_REF_BIT      = 1;
    localparam int RUN_OSC_OVF_BIT  = 2;
    localparam int RUN_WIN_OVF_BIT  = 3;
    localparam int IRQ_SENSOR_BIT   = 0;
    localparam int IRQ_REF_BIT      = 1;

    // ====================================================================
    // reset values
    localparam logic [NIB_W-1:0]  NIB_RESET  = 4'h0;
    localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;

    // ====================================================================
    // bus encodings
    localparam int         HTRANS_ACTIVE_BIT = 1;
    localparam logic       HRESP_OKAY        = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REF,
        ST_SENSOR
    } conv_state_t;

endpackage

// *** hw/rf_converter.sv ***
// resistance-to-frequency converter: counters, control and AHB-Lite slave
//
// Operation
// - oscillation counter counts up, nibble access
// - reference run stops when counter reaches zero
// - window overflow ends reference run, count kept
// - window counter down in reference, up in sensor
// - clock select picks fast or slow window clock
// - sensor type bit selects humidity sensor
// - channel bit selects channel one or zero
// - reference run bit starts, shows, clears itself
// - sensor run bit starts, shows, clears itself
// - counters have no reset value
// - reset clears config and run bits
// - two interrupt enable bits, reset to zero
// - two write-one-clear done flags, reset zero
// - done flags set on end or overflow
// - overflow ends run, sets flag, start clears
`timescale 1ns/1ps
module rf_converter import rf_conv_pkg::*; #(
    parameter int WIDTH = COUNT_W
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_hsel,
    input  wire logic [DATA_W-1:0] i_haddr,
    input  wire logic [1:0]        i_htrans,
    input  wire logic              i_hwrite,
    input  wire logic [2:0]        i_hsize,
    input  wire logic [DATA_W-1:0] i_hwdata,
    input  wire logic              i_hready,
    output logic                   o_hreadyout,
    output logic                   o_hresp,
    output logic      [DATA_W-1:0] o_hrdata,
    input  wire logic              i_sense_oscillator_clock,
    input  wire logic              i_slow_oscillator_clock,
    input  wire logic              i_fast_oscillator_clock,
    output logic                   o_reference_osc_enable,
    output logic                   o_sensor_osc_enable,
    output logic                   o_channel_select,
    output logic                   o_sensor_type_select,
    output logic                   o_converter_irq
);

    // ====================================================================
    // decoding helpers, shared by both counters
    function automatic logic nib_hit(input logic [IDX_W-1:0] idx,
                                     input logic [IDX_W-1:0] base);
        logic [IDX_W-1:0] off;
        off = idx - base;
        return off < IDX_W'(NIB_N);
    endfunction

    function automatic logic [NIB_SEL_W-1:0] nib_sel(
        input logic [IDX_W-1:0] idx,
        input logic [IDX_W-1:0] base);
        logic [IDX_W-1:0] off;
        off = idx - base;
        return off[NIB_SEL_W-1:0];
    endfunction

    // ====================================================================
    // declarations
    counter_if #(.WIDTH(WIDTH)) osc_c ();
    counter_if #(.WIDTH(WIDTH)) win_c ();

    conv_state_t        state_reg;
    conv_state_t        state_next;
    logic               wr_pend_reg;
    logic               rd_wait_reg;
    logic [IDX_W-1:0]   idx_reg;
    logic [DATA_W-1:0]  hrdata_reg;
    logic               window_clock_select_reg;
    logic               sensor_type_select_reg;
    logic               channel_select_reg;
    logic               osc_ovf_reg;
    logic               osc_ovf_next;
    logic               win_ovf_reg;
    logic               win_ovf_next;
    logic               ref_irq_en_reg;
    logic               sensor_irq_en_reg;
    logic               ref_flag_reg;
    logic               ref_flag_next;
    logic               sensor_flag_reg;
    logic               sensor_flag_next;
    logic               sense_prev_reg;
    logic               slow_prev_reg;
    logic               fast_prev_reg;

    // ====================================================================
    // bus address phase and write strobes
    wire addr_take = i_hsel && i_htrans[HTRANS_ACTIVE_BIT] && i_hready;
    wire [IDX_W-1:0] addr_idx = i_haddr[ADDR_MSB:ADDR_LSB];
    wire [NIB_W-1:0] wdata    = i_hwdata[NIB_W-1:0];

    // one compare per register, shared by write strobes and read mux
    wire sel_cfg  = idx_reg == IDX_CONFIG;
    wire sel_run  = idx_reg == IDX_RUN;
    wire sel_en   = idx_reg == IDX_IRQ_EN;
    wire sel_flag = idx_reg == IDX_IRQ_FLAG;
    wire wr_cfg   = wr_pend_reg && sel_cfg;
    wire wr_run   = wr_pend_reg && sel_run;
    wire wr_irqen = wr_pend_reg && sel_en;
    wire wr_flag  = wr_pend_reg && sel_flag;
    wire osc_hit  = nib_hit(idx_reg, IDX_OSC_CNT);
    wire win_hit  = nib_hit(idx_reg, IDX_WIN_CNT);

    // ====================================================================
    // run control
    wire idle      = state_reg == ST_IDLE;
    wire running   = !idle;
    wire in_ref    = state_reg == ST_REF;
    wire in_sensor = state_reg == ST_SENSOR;

    // a start while a run is active is ignored; reference wins a tie
    wire start_ref    = wr_run && wdata[RUN_REF_BIT] && idle;
    wire start_sensor = wr_run && wdata[RUN_SENSOR_BIT]
                        && !wdata[RUN_REF_BIT] && idle;
    wire start_any    = start_ref || start_sensor;

    // ====================================================================
    // oscillator clocks taken as synchronous levels, rising edges counted
    wire sense_tick = i_sense_oscillator_clock && !sense_prev_reg;
    wire slow_tick  = i_slow_oscillator_clock && !slow_prev_reg;
    wire fast_tick  = i_fast_oscillator_clock && !fast_prev_reg;
    wire win_tick   = window_clock_select_reg ? fast_tick
                                              : slow_tick;

    // ====================================================================
    // counter control; nothing counts while idle
    assign osc_c.wr_en     = wr_pend_reg && osc_hit;
    assign osc_c.wr_nibble = nib_sel(idx_reg, IDX_OSC_CNT);
    assign osc_c.wr_data   = wdata;
    assign osc_c.step      = running && sense_tick;
    assign osc_c.down      = 1'b0;

    assign win_c.wr_en     = wr_pend_reg && win_hit;
    assign win_c.wr_nibble = nib_sel(idx_reg, IDX_WIN_CNT);
    assign win_c.wr_data   = wdata;
    assign win_c.step      = running && win_tick;
    assign win_c.down      = in_ref;

    nibble_counter #(.WIDTH(WIDTH)) u_osc_counter (
        .i_clk  (i_clk),
        .port_c (osc_c)
    );

    nibble_counter #(.WIDTH(WIDTH)) u_win_counter (
        .i_clk  (i_clk),
        .port_c (win_c)
    );

    // ====================================================================
    // end of run events
    // reference run: oscillation counter rolling to zero is the normal end
    wire ref_osc_done = in_ref && osc_c.lands_zero;
    // window counter coming back to zero after a full down count
    wire ref_win_ovf  = in_ref && win_c.lands_zero;
    // sensor run: window counter climbing to zero closes the window
    wire sen_win_done = in_sensor && win_c.lands_zero;
    wire sen_osc_ovf  = in_sensor && osc_c.lands_zero;
    wire ref_end      = ref_osc_done || ref_win_ovf;
    wire sen_end      = sen_win_done || sen_osc_ovf;

    // ====================================================================
    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_ref) begin
                    state_next = ST_REF;
                end else if (start_sensor) begin
                    state_next = ST_SENSOR;
                end
            end
            ST_REF: begin
                if (ref_end) begin
                    state_next = ST_IDLE;
                end
            end
            ST_SENSOR: begin
                if (sen_end) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ====================================================================
    // flags: hardware set wins over a software clear in the same cycle
    wire clr_osc_ovf = (wr_run && wdata[RUN_OSC_OVF_BIT]) || start_any;
    wire clr_win_ovf = (wr_run && wdata[RUN_WIN_OVF_BIT]) || start_any;
    wire clr_ref     = wr_flag && wdata[IRQ_REF_BIT];
    wire clr_sensor  = wr_flag && wdata[IRQ_SENSOR_BIT];

    assign osc_ovf_next     = (osc_ovf_reg && !clr_osc_ovf)
                              || sen_osc_ovf;
    assign win_ovf_next     = (win_ovf_reg && !clr_win_ovf)
                              || ref_win_ovf;
    assign ref_flag_next    = (ref_flag_reg && !clr_ref)
                              || ref_end;
    assign sensor_flag_next = (sensor_flag_reg && !clr_sensor)
                              || sen_end;

    // ====================================================================
    // read data selection
    wire [NIB_W-1:0] cfg_nib = {1'b0, window_clock_select_reg,
                                sensor_type_select_reg,
                                channel_select_reg};
    wire [NIB_W-1:0] run_nib = {win_ovf_reg, osc_ovf_reg,
                                in_ref, in_sensor};
    wire [NIB_W-1:0] en_nib  = {2'b00, ref_irq_en_reg, sensor_irq_en_reg};
    wire [NIB_W-1:0] flg_nib = {2'b00, ref_flag_reg, sensor_flag_reg};
    wire [NIB_W-1:0] osc_nib =
        osc_c.value[nib_sel(idx_reg, IDX_OSC_CNT)*NIB_W +: NIB_W];
    wire [NIB_W-1:0] win_nib =
        win_c.value[nib_sel(idx_reg, IDX_WIN_CNT)*NIB_W +: NIB_W];

    wire [NIB_W-1:0] read_nib =
        sel_cfg  ? cfg_nib :
        sel_run  ? run_nib :
        osc_hit  ? osc_nib :
        win_hit  ? win_nib :
        sel_en   ? en_nib  :
        sel_flag ? flg_nib : NIB_RESET;
    wire [DATA_W-1:0] read_word = {{(DATA_W-NIB_W){1'b0}}, read_nib};

    // ====================================================================
    // bus slave: writes complete with no wait, reads take one wait state
    // so that read data always leave a flip-flop
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_pend_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            idx_reg     <= '0;
            hrdata_reg  <= WORD_RESET;
        end else begin
            wr_pend_reg <= addr_take && i_hwrite;
            rd_wait_reg <= addr_take && !i_hwrite;
            if (addr_take) begin
                idx_reg <= addr_idx;
            end
            if (rd_wait_reg) begin
                hrdata_reg <= read_word;
            end
        end
    end

    // ====================================================================
    // control registers
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            window_clock_select_reg <= 1'b0;
            sensor_type_select_reg  <= 1'b0;
            channel_select_reg      <= 1'b0;
        end else begin
            if (wr_cfg) begin
                window_clock_select_reg <= wdata[CFG_CLKSEL_BIT];
                sensor_type_select_reg  <= wdata[CFG_TYPE_BIT];
                channel_select_reg      <= wdata[CFG_CHANNEL_BIT];
            end
        end
    end

    // interrupt enables
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ref_irq_en_reg    <= 1'b0;
            sensor_irq_en_reg <= 1'b0;
        end else begin
            if (wr_irqen) begin
                ref_irq_en_reg    <= wdata[IRQ_REF_BIT];
                sensor_irq_en_reg <= wdata[IRQ_SENSOR_BIT];
            end
        end
    end

    // ====================================================================
    // run state and flags
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg       <= ST_IDLE;
        end else begin
            state_reg       <= state_next;
        end
    end

    // set beats a same-cycle clear, folded into the _next terms
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            osc_ovf_reg     <= 1'b0;
            win_ovf_reg     <= 1'b0;
            ref_flag_reg    <= 1'b0;
            sensor_flag_reg <= 1'b0;
        end else begin
            osc_ovf_reg     <= osc_ovf_next;
            win_ovf_reg     <= win_ovf_next;
            ref_flag_reg    <= ref_flag_next;
            sensor_flag_reg <= sensor_flag_next;
        end
    end

    // ====================================================================
    // oscillator edge history
    // a false tick right after reset is harmless: nothing counts idle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sense_prev_reg  <= 1'b0;
            slow_prev_reg   <= 1'b0;
            fast_prev_reg   <= 1'b0;
        end else begin
            sense_prev_reg  <= i_sense_oscillator_clock;
            slow_prev_reg   <= i_slow_oscillator_clock;
            fast_prev_reg   <= i_fast_oscillator_clock;
        end
    end

    // ====================================================================
    // outputs
    assign o_hreadyout            = !rd_wait_reg;
    assign o_hresp                = HRESP_OKAY;
    assign o_hrdata               = hrdata_reg;
    assign o_reference_osc_enable = in_ref;
    assign o_sensor_osc_enable    = in_sensor;
    assign o_channel_select       = channel_select_reg;
    assign o_sensor_type_select   = sensor_type_select_reg;
    // flags rise regardless of the enables; only the request is gated
    assign o_converter_irq = (ref_flag_reg && ref_irq_en_reg)
                             || (sensor_flag_reg && sensor_irq_en_reg);

endmodule
